// ===== testbench/rafc_mac_model.sv
// MAC transmit side as seen by the flow trigger: sends each requested pause frame.
// Assumes the request is a level held until the one-cycle sent pulse.
`timescale 1ns/1ps
module rafc_mac_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_pause_req,
    input  wire logic [3:0] i_slot_wait,
    output logic            o_pause_sent
);
    int unsigned wait_cnt;
    initial o_pause_sent = 1'b0;
    ////////////////////////////////////////////////////////////
    // Frame goes out at the next free slot; the wait models a frame already on the wire
    always @(negedge i_clk) begin
        o_pause_sent <= 1'b0;
        if (!i_rst_b || !i_pause_req || o_pause_sent) begin
            wait_cnt <= 0;
        end else if (wait_cnt >= i_slot_wait) begin
            o_pause_sent <= 1'b1;
            wait_cnt <= 0;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule

// ===== testbench/rafc_monitor.sv
// Concurrent checks on the pause handshake, paused flag and back pressure outputs.
// Assumes a bind onto rafc_top; only top-level ports are watched.
`timescale 1ns/1ps
module rafc_monitor #(
    parameter int unsigned CYC_PER_US = 200
) (
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_full_duplex,
    input wire logic        i_tx_enable,
    input wire logic [15:0] i_pause_time_value,
    input wire logic        i_rx_preamble,
    input wire logic        i_rx_addr_valid,
    input wire logic        i_pause_sent,
    input wire logic        o_pause_req,
    input wire logic [15:0] o_pause_time,
    input wire logic        o_jam,
    input wire logic        o_paused
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////
    sequence s_sent;
        o_pause_req && i_pause_sent;
    endsequence
    sequence s_jam_start;
        $rose(o_jam);
    endsequence
    a_pause_held: assert property (o_pause_req && !i_pause_sent && i_tx_enable && i_full_duplex |=> o_pause_req)
        else $error("pause request dropped before it was sent");
    a_tx_off: assert property (!i_tx_enable |=> !o_jam && !o_pause_req)
        else $error("flow action while transmitter off");
    a_fd_no_jam: assert property (i_full_duplex |=> !o_jam)
        else $error("back pressure in full duplex");
    a_hd_no_pause: assert property (!i_full_duplex |=> !o_pause_req)
        else $error("pause request in half duplex");
    a_resume_zero: assert property (o_paused && o_pause_req |-> o_pause_time == 16'h0000)
        else $error("resume pause time not zero");
    a_req_drop: assert property (s_sent |=> !o_pause_req)
        else $error("pause request repeated after send");
    a_time_src: assert property ($rose(o_pause_req) && !o_paused |-> o_pause_time == $past(i_pause_time_value))
        else $error("pause time not taken from flow register");
    a_paused_set: assert property ($rose(o_paused) |-> $past(o_pause_req) && $past(i_pause_sent))
        else $error("paused flag set without a sent pause");
    a_paused_clear: assert property ($fell(o_paused) && $past(i_tx_enable) && $past(i_full_duplex)
        |-> $past(o_pause_req) && $past(i_pause_sent))
        else $error("paused flag cleared without a sent resume");
    a_jam_hold: assert property (s_jam_start ##[1:7] $fell(o_jam) |-> !$past(i_tx_enable) || $past(i_full_duplex))
        else $error("back pressure shorter than minimum");
    a_jam_cause: assert property (s_jam_start |-> $past(i_rx_preamble) || $past(i_rx_addr_valid))
        else $error("back pressure without a received frame");
endmodule

bind rafc_top rafc_monitor #(.CYC_PER_US(CYC_PER_US)) u_mon (
    .i_clk, .i_rst_b, .i_full_duplex, .i_tx_enable, .i_pause_time_value, .i_rx_preamble,
    .i_rx_addr_valid, .i_pause_sent, .o_pause_req, .o_pause_time, .o_jam, .o_paused
);

// ===== testbench/testbench.sv
// Self-checking bench for the receive flow trigger, MAC partner attached.
// Assumes the microsecond count is shortened to two cycles.
`timescale 1ns/1ps
`include "rafc_map.svh"
module testbench;
    localparam int CPU = 2;
    logic        i_clk, i_rst_b, i_reg_wr, i_reg_rd, i_full_duplex, i_speed_100, i_tx_enable;
    logic        i_rx_preamble, i_rx_addr_valid, i_rx_group, i_rx_all_stations, i_rx_own_address;
    logic        i_pause_sent, o_pause_req, o_jam, o_paused;
    logic [7:0]  i_reg_addr;
    logic [31:0] i_reg_wdata, o_reg_rdata, rd, w;
    logic [15:0] i_pause_time_value, o_pause_time;
    logic [14:0] i_fill_bytes;
    logic [3:0]  slot_wait;
    logic [15:0] exp_q[$];
    int          miscompares, comparisons, n, e;

    rafc_top #(.CYC_PER_US(CPU)) uut (
        .i_clk, .i_rst_b, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
        .i_full_duplex, .i_speed_100, .i_tx_enable, .i_pause_time_value, .i_fill_bytes,
        .i_rx_preamble, .i_rx_addr_valid, .i_rx_group, .i_rx_all_stations, .i_rx_own_address,
        .i_pause_sent, .o_pause_req, .o_pause_time, .o_jam, .o_paused
    );
    rafc_mac_model u_mac (.i_clk, .i_rst_b, .i_pause_req(o_pause_req), .i_slot_wait(slot_wait),
        .o_pause_sent(i_pause_sent));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_count(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            miscompares++;
            $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge i_clk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a);
        @(negedge i_clk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        rd = o_reg_rdata;
    endtask
    // Low level always kept under the high level by the callers
    task automatic set_cfg(input int hi, input int lo, input int dur, input int sel);
        reg_wr(8'hAC, 32'((hi << 16) | (lo << 8) | (dur << 4) | sel));
    endtask
    task automatic frame(input int k);
        @(negedge i_clk);
        i_rx_preamble = (k == 0);
        i_rx_addr_valid = (k != 0);
        i_rx_group = (k == 1);
        i_rx_all_stations = (k == 2);
        i_rx_own_address = (k == 3);
        @(negedge i_clk);
        i_rx_preamble = 1'b0;
        i_rx_addr_valid = 1'b0;
    endtask
    task automatic quiet(input int k);
        n = 0;
        repeat (k) begin
            @(negedge i_clk);
            n += int'(o_pause_req === 1'b1) + int'(o_jam === 1'b1);
        end
    endtask
    task automatic jam_len;
        n = 0;
        while (o_jam === 1'b1 && n < 3000) begin
            n++;
            @(negedge i_clk);
        end
    endtask
    task automatic wait_req;
        n = 0;
        while (o_pause_req !== 1'b1 && n < 40) begin
            n++;
            @(negedge i_clk);
        end
        check_count(int'(o_pause_req === 1'b1), 1);
        check_word(32'(o_pause_time), 32'(exp_q.pop_front()));
        while (o_pause_req === 1'b1 && n < 80) begin
            n++;
            @(negedge i_clk);
        end
        check_count(int'(n < 80), 1);
    endtask
    function automatic int jam_cyc(input int code, input int s100);
        int us;
        us = (code < 4) ? ((code == 3) ? 25 : 5 * (code + 1)) : 50 * (code - 3);
        return us * CPU + (s100 ? 0 : (2200 * CPU) / 1000);
    endfunction

    initial begin
        #150_000;
        miscompares++;
        test_done;
    end
    initial begin
        {i_reg_wr, i_reg_rd, i_full_duplex, i_speed_100, i_rx_preamble, i_rx_addr_valid} = '0;
        {i_rx_group, i_rx_all_stations, i_rx_own_address, i_reg_addr, i_reg_wdata} = '0;
        {i_pause_time_value, i_fill_bytes, slot_wait} = '0;
        i_tx_enable = 1'b1;
        i_rst_b = 1'b0;
        void'($urandom(74109));
        repeat (16) @(negedge i_clk);
        i_rst_b = 1'b1;
        reg_rd(8'hAC);
        check_word(rd, `RAFC_CFG_RESET);
        for (int i = 0; i < 4; i++) begin
            w = $urandom;
            reg_wr(8'hAC, w);
            reg_wr(8'hA8, ~w);
            reg_rd(8'hAC);
            check_word(rd, w & 32'h00FF_FFFF);
            reg_rd(8'hB0);
            check_word(rd, 32'h0000_0000);
        end
        i_rst_b = 1'b0;
        repeat (3) @(negedge i_clk);
        i_rst_b = 1'b1;
        reg_rd(8'hAC);
        check_word(rd, `RAFC_CFG_RESET);
        // Full duplex: pause on high crossing, resume below low
        i_full_duplex = 1'b1;
        slot_wait = 4'($urandom);
        i_pause_time_value = 16'($urandom);
        set_cfg(4, 2, 0, 1);
        i_fill_bytes = 15'd255;
        quiet(8);
        check_count(n, 0);
        i_fill_bytes = 15'd256;
        exp_q.push_back(i_pause_time_value);
        wait_req();
        quiet(20);
        check_count(n, 0);
        check_word(32'(o_paused), 32'h0000_0001);
        slot_wait = 4'($urandom);
        i_fill_bytes = 15'd128;
        quiet(8);
        check_count(n, 0);
        i_fill_bytes = 15'd127;
        exp_q.push_back(16'h0000);
        wait_req();
        check_word(32'(o_paused), 32'h0000_0000);
        quiet(10);
        check_count(n, 0);
        set_cfg(4, 2, 0, 14);
        i_fill_bytes = 15'd300;
        for (int k = 0; k < 4; k++) frame(k);
        quiet(12);
        check_count(n, 0);
        i_fill_bytes = 15'd0;
        i_tx_enable = 1'b0;
        set_cfg(4, 2, 0, 1);
        i_fill_bytes = 15'd300;
        quiet(10);
        check_count(n, 0);
        i_full_duplex = 1'b0;
        frame(0);
        quiet(12);
        check_count(n, 0);
        i_tx_enable = 1'b1;
        // Half duplex: every duration code at a random speed
        for (int c = 0; c < 16; c++) begin
            i_speed_100 = 1'($urandom);
            set_cfg(4, 2, c, 1);
            frame(0);
            jam_len();
            check_count(n, jam_cyc(c, int'(i_speed_100)));
        end
        i_fill_bytes = 15'd100;
        set_cfg(4, 2, 0, 15);
        for (int k = 0; k < 4; k++) frame(k);
        quiet(12);
        check_count(n, 0);
        i_fill_bytes = 15'd300;
        for (int s = 1; s < 16; s++) begin
            for (int k = 1; k < 4; k++) begin
                set_cfg(4, 2, 0, s);
                frame(k);
                jam_len();
                e = ((s & 1) == 0 && ((s >> (4 - k)) & 1)) ? jam_cyc(0, int'(i_speed_100)) : 0;
                check_count(n, e);
            end
        end
        test_done;
    end
endmodule

// ===== verilog/rafc_jam_timer.sv
// Back-pressure duration timer: loads a cycle count from the 4-bit duration code.
// Assumes i_start is a one-cycle pulse; a new start while running restarts the period.
`timescale 1ns/1ps
`include "rafc_map.svh"

module rafc_jam_timer #(
    parameter int unsigned CYC_PER_US = `RAFC_CLK_MHZ
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_start,
    input  wire logic        i_abort,
    input  wire logic [3:0]  i_code,
    input  wire logic        i_speed_100,
    output logic             o_active
);

    localparam int unsigned EXTRA_CYC = (`RAFC_JAM_EXTRA_NS * CYC_PER_US) / 1000;

    logic [`RAFC_JAM_CNT_W-1:0] count;
    logic [`RAFC_JAM_CNT_W-1:0] load_cycles;
    int unsigned                 dur_us;

    always_comb begin
        case (i_code)
            4'h0:    dur_us = `RAFC_JAM_US_0;
            4'h1:    dur_us = `RAFC_JAM_US_1;
            4'h2:    dur_us = `RAFC_JAM_US_2;
            4'h3:    dur_us = `RAFC_JAM_US_3;
            default: dur_us = `RAFC_JAM_US_STEP * (32'(i_code) - `RAFC_JAM_STEP_BASE);
        endcase
    end

    // 10 Mb/s adds a fixed extra time on every code
    assign load_cycles = `RAFC_JAM_CNT_W'(dur_us * CYC_PER_US + (i_speed_100 ? 0 : EXTRA_CYC));

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || i_abort) begin
            count    <= '0;
            o_active <= 1'b0;
        end else if (i_start) begin
            count    <= load_cycles - `RAFC_JAM_CNT_W'(1);
            o_active <= 1'b1;
        end else if (count != '0) begin
            count    <= count - `RAFC_JAM_CNT_W'(1);
        end else begin
            o_active <= 1'b0;
        end
    end

endmodule

// ===== verilog/rafc_level_cmp.sv
// Compares the receive data FIFO fill against the high and low levels.
// Assumes the fill count is in bytes and synchronous to i_clk.
`timescale 1ns/1ps
`include "rafc_map.svh"

module rafc_level_cmp (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_b,
    input  wire logic [`RAFC_FILL_W-1:0]   i_fill_bytes,
    input  wire logic [7:0]                i_high_level,
    input  wire logic [7:0]                i_low_level,
    output logic                           o_high_reached,
    output logic                           o_below_low
);

    localparam logic [`RAFC_FILL_W-`RAFC_UNIT_SHIFT-9:0] PAD = '0;

    logic [`RAFC_FILL_W-1:0] high_bytes;
    logic [`RAFC_FILL_W-1:0] low_bytes;

    assign high_bytes = {PAD, i_high_level, {`RAFC_UNIT_SHIFT{1'b0}}};
    assign low_bytes  = {PAD, i_low_level, {`RAFC_UNIT_SHIFT{1'b0}}};

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_high_reached <= 1'b0;
            o_below_low    <= 1'b0;
        end else begin
            o_high_reached <= (i_fill_bytes >= high_bytes);
            o_below_low    <= (i_fill_bytes < low_bytes);
        end
    end

endmodule

// ===== verilog/rafc_map.svh
// Offsets, field positions, reset values and timing figures for the receive flow trigger.
// Assumes inclusion by bare name from each design file that needs a number.
`ifndef RAFC_MAP_SVH
`define RAFC_MAP_SVH

// Register map
`define RAFC_ADDR_W          8
`define RAFC_CFG_OFFSET      8'hAC
`define RAFC_CFG_RESET       32'h0000_0000
`define RAFC_CFG_WMASK       32'h00FF_FFFF

// Field positions of the configuration register
`define RAFC_HI_MSB          23
`define RAFC_HI_LSB          16
`define RAFC_LO_MSB          15
`define RAFC_LO_LSB          8
`define RAFC_DUR_MSB         7
`define RAFC_DUR_LSB         4
`define RAFC_GROUP_BIT       3
`define RAFC_ALLST_BIT       2
`define RAFC_OWN_BIT         1
`define RAFC_EVERY_BIT       0

// Levels count in 64-byte units
`define RAFC_UNIT_SHIFT      6
`define RAFC_FILL_W          15

// Pause times
`define RAFC_ZERO_PAUSE      16'h0000

// Clock and jam timing
`define RAFC_CLK_MHZ         200
`define RAFC_JAM_US_0        5
`define RAFC_JAM_US_1        10
`define RAFC_JAM_US_2        15
`define RAFC_JAM_US_3        25
`define RAFC_JAM_US_STEP     50
`define RAFC_JAM_STEP_BASE   3
`define RAFC_JAM_EXTRA_NS    2200
`define RAFC_JAM_CNT_W       18

`endif

// ===== verilog/rafc_pkg.sv
// Types shared by the receive flow trigger files.
// Assumes the numeric constants live in rafc_map.svh.
package rafc_pkg;

    typedef enum logic [1:0] {
        RAFC_IDLE,
        RAFC_PAUSE_WAIT,
        RAFC_PAUSED,
        RAFC_RESUME_WAIT
    } rafc_state_t;

endpackage

// ===== verilog/rafc_top.sv
// Automatic receive flow-control trigger: configuration register, pause requests, back pressure.
// Assumes the MAC acknowledges each pause request with a one-cycle pulse when it sends the frame,
// and that receive frame events are one-cycle pulses synchronous to i_clk.
//
// Function
// - Trigger when FIFO fill reaches high level, counted in 64-byte units.
// - Full duplex sends one pause frame per high-level crossing, never a stream.
// - Triggered pause frame carries the MAC flow register pause time.
// - Half duplex jams each matching frame for the programmed duration.
// - Fill dropping below low level sends a zero-time pause frame.
// - Zero pause only after a high-level pause frame was sent.
// - Duration field sets jam length and does nothing in full duplex.
// - Duration codes map to 5..600 us, plus 2.2 us at 10 Mb/s.
// - Group-address selector jams on multicast frames, half duplex only.
// - All-stations selector jams on broadcast frames, half duplex only.
// - Own-address selector jams on frames for this station, half duplex only.
// - Every-frame selector enables flow control; only it works in full duplex.
// - Half duplex every-frame mode acts on the next valid preamble.
// - Full duplex every-frame mode requests pause at once, held until sent.
// - Every-frame selector overrides the other three selectors.
// - Transmitter disabled: no pause frames and no back pressure.
`timescale 1ns/1ps
`include "rafc_map.svh"

module rafc_top #(
    parameter int unsigned CYC_PER_US = `RAFC_CLK_MHZ
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_b,
    // Register access
    input  wire logic [`RAFC_ADDR_W-1:0]   i_reg_addr,
    input  wire logic                      i_reg_wr,
    input  wire logic                      i_reg_rd,
    input  wire logic [31:0]               i_reg_wdata,
    output logic [31:0]                    o_reg_rdata,
    // MAC status
    input  wire logic                      i_full_duplex,
    input  wire logic                      i_speed_100,
    input  wire logic                      i_tx_enable,
    input  wire logic [15:0]               i_pause_time_value,
    // Receive side
    input  wire logic [`RAFC_FILL_W-1:0]   i_fill_bytes,
    input  wire logic                      i_rx_preamble,
    input  wire logic                      i_rx_addr_valid,
    input  wire logic                      i_rx_group,
    input  wire logic                      i_rx_all_stations,
    input  wire logic                      i_rx_own_address,
    // Pause request to the MAC
    input  wire logic                      i_pause_sent,
    output logic                           o_pause_req,
    output logic [15:0]                    o_pause_time,
    // Back pressure and state
    output logic                           o_jam,
    output logic                           o_paused
);

////////////////////////////////////////////////////////////////////////////////
// Configuration register

    logic [31:0] auto_flow_config;
    logic [31:0] next_rdata;

    logic [7:0]  flow_high_level;
    logic [7:0]  flow_low_level;
    logic [3:0]  jam_duration;
    logic        jam_on_group_frame;
    logic        jam_on_all_stations_frame;
    logic        jam_on_own_address;
    logic        flow_on_every_frame;

    wire         cfg_hit;
    wire         cfg_write;

    assign cfg_hit   = (i_reg_addr == `RAFC_CFG_OFFSET);
    assign cfg_write = cfg_hit && i_reg_wr;

    assign flow_high_level           = auto_flow_config[`RAFC_HI_MSB:`RAFC_HI_LSB];
    assign flow_low_level            = auto_flow_config[`RAFC_LO_MSB:`RAFC_LO_LSB];
    assign jam_duration              = auto_flow_config[`RAFC_DUR_MSB:`RAFC_DUR_LSB];
    assign jam_on_group_frame        = auto_flow_config[`RAFC_GROUP_BIT];
    assign jam_on_all_stations_frame = auto_flow_config[`RAFC_ALLST_BIT];
    assign jam_on_own_address        = auto_flow_config[`RAFC_OWN_BIT];
    assign flow_on_every_frame       = auto_flow_config[`RAFC_EVERY_BIT];

    // Reserved bits 31:24 read as zero and ignore writes
    assign next_rdata = (i_reg_rd && cfg_hit) ? (auto_flow_config & `RAFC_CFG_WMASK) : 32'h0000_0000;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            auto_flow_config <= `RAFC_CFG_RESET;
        end else if (cfg_write) begin
            auto_flow_config <= i_reg_wdata & `RAFC_CFG_WMASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 32'h0000_0000;
        end else begin
            o_reg_rdata <= next_rdata;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Fill level comparison

    logic high_reached;
    logic below_low;

    rafc_level_cmp u_level_cmp (
        .i_clk          (i_clk),
        .i_rst_b        (i_rst_b),
        .i_fill_bytes   (i_fill_bytes),
        .i_high_level   (flow_high_level),
        .i_low_level    (flow_low_level),
        .o_high_reached (high_reached),
        .o_below_low    (below_low)
    );

////////////////////////////////////////////////////////////////////////////////
// Configuration change guard

    // The level compare is registered, so for one cycle after a write its outputs
    // still reflect the old thresholds. Acting on them together with the new
    // selectors could raise a pause or a jam that the new levels never asked for.
    // The cost is one cycle of extra latency right after a configuration write.
    logic cfg_fresh;
    wire  high_ok;
    wire  low_ok;

    assign high_ok = high_reached && !cfg_fresh;
    assign low_ok  = below_low && !cfg_fresh;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cfg_fresh <= 1'b0;
        end else begin
            cfg_fresh <= cfg_write;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Enable decode

    wire any_selector;
    wire fdx_enabled;
    wire hdx_enabled;
    wire addr_match;
    wire hdx_trigger;

    // Any selector set means automatic flow control is enabled in half duplex
    assign any_selector = flow_on_every_frame |
                          jam_on_group_frame |
                          jam_on_all_stations_frame |
                          jam_on_own_address;

    // Only the every-frame selector counts in full duplex
    assign fdx_enabled = i_tx_enable && i_full_duplex && flow_on_every_frame;

    // Other selectors are ignored in full duplex by gating on half duplex
    assign hdx_enabled = i_tx_enable && !i_full_duplex && any_selector;

    assign addr_match = (jam_on_group_frame && i_rx_group) ||
                        (jam_on_all_stations_frame && i_rx_all_stations) ||
                        (jam_on_own_address && i_rx_own_address);

    // Every-frame starts at the preamble and skips address decode; it overrides bits 3:1
    assign hdx_trigger = hdx_enabled && high_ok &&
                         (flow_on_every_frame ? i_rx_preamble
                                              : (i_rx_addr_valid && addr_match));

////////////////////////////////////////////////////////////////////////////////
// Half-duplex back pressure

    wire jam_abort;

    // Losing the transmitter or leaving half duplex ends back pressure at once
    assign jam_abort = !i_tx_enable || i_full_duplex;

    rafc_jam_timer #(
        .CYC_PER_US (CYC_PER_US)
    ) u_jam_timer (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_start     (hdx_trigger),
        .i_abort     (jam_abort),
        .i_code      (jam_duration),
        .i_speed_100 (i_speed_100),
        .o_active    (o_jam)
    );

////////////////////////////////////////////////////////////////////////////////
// Full-duplex pause sequencing

    rafc_pkg::rafc_state_t state;
    rafc_pkg::rafc_state_t next_state;

    logic        paused_flag;
    logic        next_paused_flag;
    logic        next_pause_req;
    logic [15:0] next_pause_time;

    always_comb begin
        next_state       = state;
        next_paused_flag = paused_flag;
        next_pause_req   = o_pause_req;
        next_pause_time  = o_pause_time;
        case (state)
            rafc_pkg::RAFC_IDLE: begin
                next_pause_req = 1'b0;
                if (fdx_enabled && high_ok) begin
                    // Request at once; the MAC sends it in its next free slot
                    next_state      = rafc_pkg::RAFC_PAUSE_WAIT;
                    next_pause_req  = 1'b1;
                    next_pause_time = i_pause_time_value;
                end
            end
            rafc_pkg::RAFC_PAUSE_WAIT: begin
                if (i_pause_sent) begin
                    // One frame per crossing: stay paused until the zero pause goes out
                    next_state       = rafc_pkg::RAFC_PAUSED;
                    next_pause_req   = 1'b0;
                    next_paused_flag = 1'b1;
                end
            end
            rafc_pkg::RAFC_PAUSED: begin
                next_pause_req = 1'b0;
                // Only reachable after a sent high pause, so no stray zero pause
                if (low_ok) begin
                    next_state      = rafc_pkg::RAFC_RESUME_WAIT;
                    next_pause_req  = 1'b1;
                    next_pause_time = `RAFC_ZERO_PAUSE;
                end
            end
            rafc_pkg::RAFC_RESUME_WAIT: begin
                if (i_pause_sent) begin
                    next_state       = rafc_pkg::RAFC_IDLE;
                    next_pause_req   = 1'b0;
                    next_paused_flag = 1'b0;
                end
            end
            default: begin
                next_state       = rafc_pkg::RAFC_IDLE;
                next_pause_req   = 1'b0;
                next_paused_flag = 1'b0;
            end
        endcase
        // A disabled transmitter or a drop out of full duplex withdraws any request
        if (!i_tx_enable || !i_full_duplex) begin
            next_state       = rafc_pkg::RAFC_IDLE;
            next_pause_req   = 1'b0;
            next_paused_flag = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state        <= rafc_pkg::RAFC_IDLE;
            paused_flag  <= 1'b0;
            o_pause_req  <= 1'b0;
            o_pause_time <= 16'h0000;
        end else begin
            state        <= next_state;
            paused_flag  <= next_paused_flag;
            o_pause_req  <= next_pause_req;
            o_pause_time <= next_pause_time;
        end
    end

    // Separate output copy keeps o_paused straight from a flip-flop
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_paused <= 1'b0;
        end else begin
            o_paused <= next_paused_flag;
        end
    end

endmodule
